// *** verilog/relay_ctl_pkg.sv ***
// constants shared by the relay output control files
// assumes a single 250 MHz clock domain and asynchronous active-low reset
package relay_ctl_pkg;
  localparam int unsigned NUM_ALARM_SRC = 12;
  // alarm source bit positions
  localparam int unsigned SRC_GROUND = 0;
  localparam int unsigned SRC_UNDERCURRENT = 1;
  localparam int unsigned SRC_UNBALANCE = 2;
  localparam int unsigned SRC_OVERLOAD = 3;
  localparam int unsigned SRC_TEMP1 = 4;
  localparam int unsigned SRC_TEMP2 = 5;
  localparam int unsigned SRC_TEMP3 = 6;
  localparam int unsigned SRC_THERMISTOR = 7;
  localparam int unsigned SRC_OPT_SW1 = 8;
  localparam int unsigned SRC_OPT_SW2 = 9;
  localparam int unsigned SRC_TEST = 10;
  localparam int unsigned SRC_POWER_LOSS = 11;
  localparam logic [NUM_ALARM_SRC-1:0] ALARM_EN_RESET = 12'h000;
  // auxiliary source selection codes
  localparam int unsigned AUX_SEL_W = 3;
  localparam logic [AUX_SEL_W-1:0] AUX_SHORT_GND = 3'h0;
  localparam logic [AUX_SEL_W-1:0] AUX_UNDERCUR = 3'h1;
  localparam logic [AUX_SEL_W-1:0] AUX_SERIAL = 3'h2;
  localparam logic [AUX_SEL_W-1:0] AUX_OPT_SW1 = 3'h3;
  localparam logic [AUX_SEL_W-1:0] AUX_OPT_SW2 = 3'h4;
  localparam logic [AUX_SEL_W-1:0] AUX_THERMISTOR = 3'h5;
  // register map, word index equals byte address / 4
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ALARM_EN = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COMMAND = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] REG_SETPOINT = 8'h18;
  // config field positions
  localparam int unsigned CFG_TRIP_FAILSAFE = 0;
  localparam int unsigned CFG_ALARM_FAILSAFE = 1;
  localparam int unsigned CFG_SELF_CLEARING = 2;
  localparam int unsigned CFG_AUX_SEL_LO = 3;
  localparam int unsigned CFG_W = 6;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
  // command register bits (write only, self clearing)
  localparam int unsigned CMD_RESET = 0;
  localparam int unsigned CMD_AUX_SET = 1;
  localparam int unsigned CMD_AUX_CLR = 2;
  // interrupt event positions
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned EV_ALARM = 0;
  localparam int unsigned EV_TRIP = 1;
  localparam int unsigned EV_FAILURE = 2;
  localparam int unsigned EV_ILLEGAL = 3;
  localparam int unsigned SETPOINT_W = 16;
  localparam logic [SETPOINT_W-1:0] SETPOINT_RESET = 16'h0000;
endpackage

// *** verilog/sticky_irq.sv ***
// sticky interrupt status with mask and read-to-clear
// assumes events are one-cycle or level pulses in the clk_i domain
module sticky_irq #(
  parameter int unsigned W = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] event_i,
  input wire logic clear_i,
  input wire logic [W-1:0] mask_i,
  output logic [W-1:0] status_o,
  output logic irq_o
);
  logic [W-1:0] status_nxt;
  logic irq_nxt;

  // a set in the clearing cycle wins so no event is lost
  always_comb begin
    status_nxt = (clear_i ? '0 : status_o) | event_i;
    irq_nxt = |(status_nxt & mask_i);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_o <= '0;
      irq_o <= 1'b0;
    end else begin
      status_o <= status_nxt;
      irq_o <= irq_nxt;
    end
  end
endmodule

// *** verilog/setpoint_guard.sv ***
// setpoint store gate for keypad and serial writers
// assumes store strobes are one cycle long and synchronous to clk_i
module setpoint_guard (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic access_i,
  input wire logic key_store_i,
  input wire logic [relay_ctl_pkg::SETPOINT_W-1:0] key_data_i,
  input wire logic ser_store_i,
  input wire logic [relay_ctl_pkg::SETPOINT_W-1:0] ser_data_i,
  output logic [relay_ctl_pkg::SETPOINT_W-1:0] setpoint_o,
  output logic illegal_o
);
  logic [relay_ctl_pkg::SETPOINT_W-1:0] setpoint_nxt;
  logic illegal_nxt;

  // serial store takes priority when both arrive together
  always_comb begin
    setpoint_nxt = setpoint_o;
    illegal_nxt = 1'b0;
    if (ser_store_i) begin
      setpoint_nxt = ser_data_i;
    end else if (key_store_i && access_i) begin
      setpoint_nxt = key_data_i;
    end
    if (key_store_i && !access_i) begin
      illegal_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      setpoint_o <= relay_ctl_pkg::SETPOINT_RESET;
      illegal_o <= 1'b0;
    end else begin
      setpoint_o <= setpoint_nxt;
      illegal_o <= illegal_nxt;
    end
  end

  a_keypad_locked: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    key_store_i && !access_i && !ser_store_i |=> $stable(setpoint_o))
    else $error("keypad store changed setpoint without access");
  a_serial_store: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    ser_store_i |=> setpoint_o == $past(ser_data_i))
    else $error("serial store not applied");
  a_keypad_store: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    key_store_i && access_i && !ser_store_i
    |=> setpoint_o == $past(key_data_i))
    else $error("keypad store with access not applied");
endmodule

// *** verilog/relay_output_control.sv ***
// output relay drive and setpoint protection for a motor protection unit
// assumes all inputs synchronous to clk_i; registers on a plain strobe port
// Notes on behaviour
// - four separate drives: trip, alarm, auxiliary, service
// - trip drive selectable failsafe or plain
// - alarm on any enabled alarm source
// - self clearing alarm drops when cause ends
// - held alarm stays until a reset request
// - auxiliary drive source is selectable
// - serial command directly sets or clears auxiliary
// - self-monitor failure de-energizes service drive
// - service drive always failsafe, energized when healthy
// - keypad store only with access input active
// - serial store ignores the access input
// - refused keypad store flags illegal access, keeps value
// - reads always allowed regardless of access input
module relay_output_control (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [relay_ctl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // protection inputs
  input wire logic trip_i,
  input wire logic [relay_ctl_pkg::NUM_ALARM_SRC-1:0] alarm_src_i,
  input wire logic short_gnd_trip_i,
  input wire logic self_fail_i,
  input wire logic key_reset_i,
  // setpoint store paths
  input wire logic access_i,
  input wire logic key_store_i,
  input wire logic [relay_ctl_pkg::SETPOINT_W-1:0] key_data_i,
  input wire logic ser_store_i,
  input wire logic [relay_ctl_pkg::SETPOINT_W-1:0] ser_data_i,
  // relay coil drives, high energizes; then the illegal access flag and the interrupt
  output logic trip_coil_o,
  output logic alarm_coil_o,
  output logic aux_coil_o,
  output logic service_coil_o,
  output logic illegal_access_o,
  output logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [relay_ctl_pkg::CFG_W-1:0] cfg_r, cfg_nxt;
  logic [relay_ctl_pkg::NUM_ALARM_SRC-1:0] alarm_en_r, alarm_en_nxt;
  logic [relay_ctl_pkg::IRQ_W-1:0] mask_r, mask_nxt;
  logic [31:0] rdata_nxt;
  logic cmd_reset, cmd_aux_set, cmd_aux_clr, irq_clear;
  logic [relay_ctl_pkg::IRQ_W-1:0] irq_status;
  logic [relay_ctl_pkg::SETPOINT_W-1:0] setpoint;
  logic illegal;
  logic trip_fail_mode, alarm_fail_mode, self_clearing_mode;
  logic [relay_ctl_pkg::AUX_SEL_W-1:0] aux_sel;

  assign trip_fail_mode = cfg_r[relay_ctl_pkg::CFG_TRIP_FAILSAFE];
  assign alarm_fail_mode = cfg_r[relay_ctl_pkg::CFG_ALARM_FAILSAFE];
  assign self_clearing_mode = cfg_r[relay_ctl_pkg::CFG_SELF_CLEARING];
  assign aux_sel = cfg_r[relay_ctl_pkg::CFG_AUX_SEL_LO +:
                         relay_ctl_pkg::AUX_SEL_W];

  // command strobes only last the write cycle
  assign cmd_reset = wr_i && addr_i == relay_ctl_pkg::REG_COMMAND &&
                     wdata_i[relay_ctl_pkg::CMD_RESET];
  assign cmd_aux_set = wr_i && addr_i == relay_ctl_pkg::REG_COMMAND &&
                       wdata_i[relay_ctl_pkg::CMD_AUX_SET];
  assign cmd_aux_clr = wr_i && addr_i == relay_ctl_pkg::REG_COMMAND &&
                       wdata_i[relay_ctl_pkg::CMD_AUX_CLR];
  assign irq_clear = rd_i && addr_i == relay_ctl_pkg::REG_IRQ_STATUS;

  ////////////////////////////////////////////////////////////////////////////
  // register write and read decode
  always_comb begin
    cfg_nxt = cfg_r;
    alarm_en_nxt = alarm_en_r;
    mask_nxt = mask_r;
    rdata_nxt = 32'h0000_0000; // unmapped reads return zero
    if (wr_i) begin
      case (addr_i)
        relay_ctl_pkg::REG_CONFIG:
          cfg_nxt = wdata_i[relay_ctl_pkg::CFG_W-1:0];
        relay_ctl_pkg::REG_ALARM_EN:
          alarm_en_nxt = wdata_i[relay_ctl_pkg::NUM_ALARM_SRC-1:0];
        relay_ctl_pkg::REG_IRQ_MASK:
          mask_nxt = wdata_i[relay_ctl_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // reads are never gated by the access input; only the status word reports it
    if (rd_i) begin
      case (addr_i)
        relay_ctl_pkg::REG_CONFIG:
          rdata_nxt = {26'h0, cfg_r};
        relay_ctl_pkg::REG_ALARM_EN:
          rdata_nxt = {20'h0, alarm_en_r};
        relay_ctl_pkg::REG_STATUS:
          rdata_nxt = {27'h0, access_i, service_coil_o, aux_coil_o,
                       alarm_coil_o, trip_coil_o};
        relay_ctl_pkg::REG_IRQ_STATUS:
          rdata_nxt = {28'h0, irq_status};
        relay_ctl_pkg::REG_IRQ_MASK:
          rdata_nxt = {28'h0, mask_r};
        relay_ctl_pkg::REG_SETPOINT:
          rdata_nxt = {16'h0, setpoint};
        default:
          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_r <= relay_ctl_pkg::CFG_RESET;
      alarm_en_r <= relay_ctl_pkg::ALARM_EN_RESET;
      mask_r <= '0;
      rdata_o <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      alarm_en_r <= alarm_en_nxt;
      mask_r <= mask_nxt;
      rdata_o <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm, auxiliary and relay state
  logic alarm_cause, reset_req;
  logic alarm_act_r, alarm_act_nxt;
  logic aux_serial_r, aux_serial_nxt;
  logic aux_src;
  logic trip_coil_nxt, alarm_coil_nxt, aux_coil_nxt, service_coil_nxt;

  assign alarm_cause = |(alarm_src_i & alarm_en_r);
  assign reset_req = key_reset_i || cmd_reset;

  always_comb begin
    // held alarm only releases on reset once the cause is gone
    if (alarm_cause) begin
      alarm_act_nxt = 1'b1;
    end else if (self_clearing_mode) begin
      alarm_act_nxt = 1'b0;
    end else if (reset_req) begin
      alarm_act_nxt = 1'b0;
    end else begin
      alarm_act_nxt = alarm_act_r;
    end
    // clear wins over set if software writes both bits
    aux_serial_nxt = aux_serial_r;
    if (cmd_aux_set) begin
      aux_serial_nxt = 1'b1;
    end
    if (cmd_aux_clr) begin
      aux_serial_nxt = 1'b0;
    end
    case (aux_sel)
      relay_ctl_pkg::AUX_SHORT_GND: aux_src = short_gnd_trip_i;
      relay_ctl_pkg::AUX_UNDERCUR:
        aux_src = alarm_src_i[relay_ctl_pkg::SRC_UNDERCURRENT];
      relay_ctl_pkg::AUX_SERIAL: aux_src = aux_serial_nxt;
      relay_ctl_pkg::AUX_OPT_SW1:
        aux_src = alarm_src_i[relay_ctl_pkg::SRC_OPT_SW1];
      relay_ctl_pkg::AUX_OPT_SW2:
        aux_src = alarm_src_i[relay_ctl_pkg::SRC_OPT_SW2];
      relay_ctl_pkg::AUX_THERMISTOR:
        aux_src = alarm_src_i[relay_ctl_pkg::SRC_THERMISTOR];
      default: aux_src = 1'b0;
    endcase
    // four independent coils; failsafe inverts so a fault drops the coil
    trip_coil_nxt = trip_fail_mode ? !trip_i : trip_i;
    alarm_coil_nxt = alarm_fail_mode ? !alarm_act_nxt : alarm_act_nxt;
    aux_coil_nxt = aux_src;
    service_coil_nxt = !self_fail_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_act_r <= 1'b0;
      aux_serial_r <= 1'b0;
      trip_coil_o <= 1'b0;
      alarm_coil_o <= 1'b0;
      aux_coil_o <= 1'b0;
      service_coil_o <= 1'b0;
    end else begin
      alarm_act_r <= alarm_act_nxt;
      aux_serial_r <= aux_serial_nxt;
      trip_coil_o <= trip_coil_nxt;
      alarm_coil_o <= alarm_coil_nxt;
      aux_coil_o <= aux_coil_nxt;
      service_coil_o <= service_coil_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // setpoint protection and interrupts
  setpoint_guard u_guard (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .access_i(access_i),
    .key_store_i(key_store_i),
    .key_data_i(key_data_i),
    .ser_store_i(ser_store_i),
    .ser_data_i(ser_data_i),
    .setpoint_o(setpoint),
    .illegal_o(illegal)
  );
  assign illegal_access_o = illegal; // flop output of the guard

  sticky_irq #(.W(relay_ctl_pkg::IRQ_W)) u_irq (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .event_i({illegal, self_fail_i, trip_i, alarm_cause}),
    .clear_i(irq_clear),
    .mask_i(mask_r),
    .status_o(irq_status),
    .irq_o(irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // alarm state against its causes and the reset requests
  a_alarm_follows: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    alarm_cause |=> alarm_act_r)
    else $error("enabled alarm source did not activate alarm");
  a_self_clear: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    self_clearing_mode && !alarm_cause |=> !alarm_act_r)
    else $error("self clearing alarm did not drop");
  a_alarm_hold: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    alarm_act_r && !self_clearing_mode && !reset_req |=> alarm_act_r)
    else $error("held alarm dropped without reset");
  a_reset_clears: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    reset_req && !alarm_cause |=> !alarm_act_r)
    else $error("reset did not clear alarm with cause gone");
  a_reset_blocked: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    reset_req && alarm_cause |=> alarm_act_r)
    else $error("reset cleared alarm while cause active");
  // coils run one cycle behind; the mode that counts is the one that
  // stood when the coil was loaded, hence the past value
  // the reset term keeps the release edge out, since coils still
  // hold their reset value one cycle after it
  a_alarm_coil: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    rst_b_i |=> alarm_coil_o == (alarm_act_r ^ $past(alarm_fail_mode)))
    else $error("alarm coil wrong for mode");
  a_trip_mode: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    ##1 trip_coil_o == ($past(trip_i) ^ $past(trip_fail_mode)))
    else $error("trip coil wrong for mode");
  a_service_drop: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    self_fail_i |=> !service_coil_o)
    else $error("service coil energized during failure");
  a_service_ok: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    rst_b_i && !self_fail_i |=> service_coil_o)
    else $error("service coil not energized when healthy");
  // auxiliary coil follows whichever source is selected
  a_aux_serial: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    aux_sel == relay_ctl_pkg::AUX_SERIAL && cmd_aux_set && !cmd_aux_clr
    |=> aux_coil_o)
    else $error("serial set did not energize auxiliary");
  a_aux_clear: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    aux_sel == relay_ctl_pkg::AUX_SERIAL && cmd_aux_clr |=> !aux_coil_o)
    else $error("serial clear did not drop auxiliary");
  a_aux_short: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    rst_b_i && aux_sel == relay_ctl_pkg::AUX_SHORT_GND
    |=> aux_coil_o == $past(short_gnd_trip_i))
    else $error("auxiliary not following short circuit trip");
  a_aux_undercur: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    aux_sel == relay_ctl_pkg::AUX_UNDERCUR
    |=> aux_coil_o == $past(alarm_src_i[relay_ctl_pkg::SRC_UNDERCURRENT]))
    else $error("auxiliary not following undercurrent");
  a_aux_switch_one: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    aux_sel == relay_ctl_pkg::AUX_OPT_SW1
    |=> aux_coil_o == $past(alarm_src_i[relay_ctl_pkg::SRC_OPT_SW1]))
    else $error("auxiliary not following option switch one");
  a_aux_switch_two: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    aux_sel == relay_ctl_pkg::AUX_OPT_SW2
    |=> aux_coil_o == $past(alarm_src_i[relay_ctl_pkg::SRC_OPT_SW2]))
    else $error("auxiliary not following option switch two");
  a_aux_thermistor: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    aux_sel == relay_ctl_pkg::AUX_THERMISTOR
    |=> aux_coil_o == $past(alarm_src_i[relay_ctl_pkg::SRC_THERMISTOR]))
    else $error("auxiliary not following thermistor");
  a_aux_off: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    aux_sel > relay_ctl_pkg::AUX_THERMISTOR |=> !aux_coil_o)
    else $error("unassigned auxiliary energized");
  // event bits and the level interrupt
  a_illegal_event: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    illegal |=> irq_status[relay_ctl_pkg::EV_ILLEGAL])
    else $error("refused store did not set its status bit");
  a_failure_event: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    self_fail_i |=> irq_status[relay_ctl_pkg::EV_FAILURE])
    else $error("self monitor failure did not set its status bit");
  a_irq_level: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    rst_b_i |=> irq_o == |(irq_status & $past(mask_r)))
    else $error("interrupt level disagrees with masked status");
  // reads are never gated by the access input
  a_read_free: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    rd_i && addr_i == relay_ctl_pkg::REG_SETPOINT
    |=> rdata_o[relay_ctl_pkg::SETPOINT_W-1:0] == $past(setpoint))
    else $error("setpoint read blocked");
  a_config_read: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    rd_i && addr_i == relay_ctl_pkg::REG_CONFIG
    |=> rdata_o[relay_ctl_pkg::CFG_W-1:0] == $past(cfg_r))
    else $error("config read wrong");
  a_read_idle: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    rst_b_i && !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside a read");
endmodule

// *** verification/relay_contacts_model.sv ***
// contact model for the four relay loads on the far side
// assumes coil drives are high to energize; LAG is contact travel time
module relay_contacts_model #(
  parameter int unsigned LAG = 2
) (
  input wire logic clk_i,
  input wire logic [3:0] coil_i,
  output logic [3:0] no_closed_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pipe_r [LAG];
  // a normally open contact closes only once its armature has moved,
  // so a bench that samples too early sees the old contact state
  always_ff @(posedge clk_i) begin
    pipe_r[0] <= coil_i;
    for (int k = 1; k < LAG; k++) begin
      pipe_r[k] <= pipe_r[k-1];
    end
  end
  assign no_closed_o = pipe_r[LAG-1];
endmodule

// *** verification/relay_output_control_tb.sv ***
// self-checking bench for the relay output control block
// assumes a 250 MHz clock and a register port answering one cycle later
module relay_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHECK(nm, exp, got) begin comparisons++; \
    if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
  logic clk, rst_b, wr, rd, trip, short_gnd, self_fail, key_reset;
  logic access, key_store, ser_store, trip_coil, alarm_coil, aux_coil;
  logic service_coil, illegal, irq;
  logic [relay_ctl_pkg::ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [relay_ctl_pkg::NUM_ALARM_SRC-1:0] alarm_src;
  logic [relay_ctl_pkg::SETPOINT_W-1:0] key_data, ser_data;
  logic [3:0] contacts;
  int num_errors = 0;
  int comparisons = 0;
  relay_output_control dut_u (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .trip_i(trip),
    .alarm_src_i(alarm_src), .short_gnd_trip_i(short_gnd),
    .self_fail_i(self_fail), .key_reset_i(key_reset), .access_i(access),
    .key_store_i(key_store), .key_data_i(key_data),
    .ser_store_i(ser_store), .ser_data_i(ser_data),
    .trip_coil_o(trip_coil), .alarm_coil_o(alarm_coil),
    .aux_coil_o(aux_coil), .service_coil_o(service_coil),
    .illegal_access_o(illegal), .irq_o(irq));
  relay_contacts_model #(.LAG(2)) loads_u (.clk_i(clk),
    .coil_i({service_coil, aux_coil, alarm_coil, trip_coil}),
    .no_closed_o(contacts));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobes are raised and dropped only at rising edges
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic expect_rd(input string nm, input logic [7:0] a,
                           input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHECK(nm, e, rdata)
  endtask
  // coils and contacts both, after the contacts have had time to travel
  task automatic coils(input string nm, input logic [3:0] e);
    tick(4);
    `CHECK(nm, e, {service_coil, aux_coil, alarm_coil, trip_coil})
    `CHECK(nm, e, contacts)
  endtask
  task automatic alarm_set(input logic [11:0] v);
    @(posedge clk);
    alarm_src <= v;
  endtask
  task automatic aux_in(input logic [5:0] m);
    logic [11:0] v;
    v = '0;
    v[relay_ctl_pkg::SRC_UNDERCURRENT] = m[1];
    v[relay_ctl_pkg::SRC_OPT_SW1] = m[3];
    v[relay_ctl_pkg::SRC_OPT_SW2] = m[4];
    v[relay_ctl_pkg::SRC_THERMISTOR] = m[5];
    @(posedge clk);
    short_gnd <= m[0];
    alarm_src <= v;
  endtask
  task automatic key_press();
    @(posedge clk);
    key_reset <= 1'b1;
    @(posedge clk);
    key_reset <= 1'b0;
  endtask
  task automatic store(input logic acc, k, s, input logic [15:0] kd, sd);
    @(posedge clk);
    access <= acc;
    key_store <= k;
    ser_store <= s;
    key_data <= kd;
    ser_data <= sd;
    @(posedge clk);
    key_store <= 1'b0;
    ser_store <= 1'b0;
    #1;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    {wr, rd, trip, short_gnd, self_fail, key_reset, access} = '0;
    {key_store, ser_store, addr, wdata, alarm_src, key_data, ser_data} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    coils("reset coils", 4'h8);
    expect_rd("config reset", relay_ctl_pkg::REG_CONFIG, 32'h0);
    reg_wr(relay_ctl_pkg::REG_CONFIG, 32'h1);
    coils("trip failsafe idle", 4'h9);
    @(posedge clk);
    trip <= 1'b1;
    coils("trip failsafe fault", 4'h8);
    reg_wr(relay_ctl_pkg::REG_CONFIG, 32'h0);
    coils("trip plain fault", 4'h9);
    @(posedge clk);
    trip <= 1'b0;
    self_fail <= 1'b1;
    coils("service on failure", 4'h0);
    @(posedge clk);
    self_fail <= 1'b0;
    coils("service healthy", 4'h8);
    $display("test trip and service done");
    // every aux source except serial, with all the other sources raised first
    for (int s = 0; s < 6; s++) begin
      if (s == 2) continue;
      reg_wr(relay_ctl_pkg::REG_CONFIG, 32'(s << 3));
      aux_in(6'h3f & ~(6'h1 << s));
      coils("aux other sources", 4'h8);
      aux_in(6'h1 << s);
      coils("aux own source", 4'hc);
      aux_in(6'h0);
    end
    // codes past the last source leave the auxiliary coil off
    reg_wr(relay_ctl_pkg::REG_CONFIG, 32'h30);
    aux_in(6'h3f);
    coils("aux unassigned", 4'h8);
    aux_in(6'h0);
    reg_wr(relay_ctl_pkg::REG_CONFIG, 32'h10);
    reg_wr(relay_ctl_pkg::REG_COMMAND, 32'h2);
    coils("aux serial set", 4'hc);
    reg_wr(relay_ctl_pkg::REG_COMMAND, 32'h6);
    coils("aux set and clear", 4'h8);
    $display("test aux done");
    reg_wr(relay_ctl_pkg::REG_CONFIG, 32'h4);
    for (int i = 0; i < 12; i++) begin
      reg_wr(relay_ctl_pkg::REG_ALARM_EN, ~(32'h1 << i));
      alarm_set(12'h1 << i);
      coils("alarm disabled source", 4'h8);
      reg_wr(relay_ctl_pkg::REG_ALARM_EN, 32'h1 << i);
      coils("alarm enabled source", 4'ha);
      alarm_set(12'h0);
      coils("alarm self clears", 4'h8);
    end
    reg_wr(relay_ctl_pkg::REG_CONFIG, 32'h6);
    coils("alarm failsafe idle", 4'ha);
    reg_wr(relay_ctl_pkg::REG_CONFIG, 32'h0);
    reg_wr(relay_ctl_pkg::REG_ALARM_EN, 32'h8);
    alarm_set(12'h8);
    coils("hold raised", 4'ha);
    alarm_set(12'h0);
    coils("hold kept", 4'ha);
    alarm_set(12'h8);
    key_press();
    coils("reset with cause", 4'ha);
    alarm_set(12'h0);
    key_press();
    coils("key reset", 4'h8);
    alarm_set(12'h8);
    coils("hold raised again", 4'ha);
    alarm_set(12'h0);
    reg_wr(relay_ctl_pkg::REG_COMMAND, 32'h1);
    coils("serial reset", 4'h8);
    $display("test alarm done");
    // alarm, trip and failure events have all been seen by now
    expect_rd("irq clear", relay_ctl_pkg::REG_IRQ_STATUS, 32'h7);
    reg_wr(relay_ctl_pkg::REG_IRQ_MASK, 32'h8);
    store(1'b0, 1'b1, 1'b0, 16'h1234, 16'h0);
    `CHECK("illegal pulse", 1'b1, illegal)
    tick(1);
    `CHECK("illegal pulse ends", 1'b0, illegal)
    expect_rd("setpoint kept", relay_ctl_pkg::REG_SETPOINT, 32'h0);
    `CHECK("irq on illegal", 1'b1, irq)
    expect_rd("irq status", relay_ctl_pkg::REG_IRQ_STATUS, 32'h8);
    tick(2);
    `CHECK("irq cleared", 1'b0, irq)
    @(posedge clk);
    trip <= 1'b1;
    @(posedge clk);
    trip <= 1'b0;
    tick(3);
    `CHECK("masked event", 1'b0, irq)
    expect_rd("trip event", relay_ctl_pkg::REG_IRQ_STATUS, 32'h2);
    store(1'b1, 1'b1, 1'b0, 16'h1234, 16'h0);
    `CHECK("no illegal pulse", 1'b0, illegal)
    expect_rd("keypad store", relay_ctl_pkg::REG_SETPOINT, 32'h1234);
    store(1'b0, 1'b0, 1'b1, 16'h0, 16'habcd);
    expect_rd("serial store", relay_ctl_pkg::REG_SETPOINT, 32'habcd);
    store(1'b1, 1'b1, 1'b1, 16'h5555, 16'h0f0f);
    expect_rd("both stores", relay_ctl_pkg::REG_SETPOINT, 32'h0f0f);
    expect_rd("status open", relay_ctl_pkg::REG_STATUS, 32'h18);
    @(posedge clk);
    access <= 1'b0;
    expect_rd("status shut", relay_ctl_pkg::REG_STATUS, 32'h08);
    expect_rd("read shut", relay_ctl_pkg::REG_SETPOINT, 32'h0f0f);
    reg_wr(8'hfc, 32'hffffffff);
    expect_rd("unmapped", 8'hfc, 32'h0);
    $display("test setpoint and irq done");
    results();
  end
endmodule
